/* File: design/umc_top.v */
// modem control, modem status, interrupt and read strobe logic of the serial element
// Summary of operation
// R1: transceiver disable high except during host reads
// R2: msr bit 5 shows data set ready
// R3: msr bit 1 flags data set ready change
// R4: data set ready change interrupts when enabled
// R5: terminal ready active low when bit set
// R6: terminal ready inactive on reset, loop, clear
// R7: interrupt on five prioritised sources
// R8: interrupt drops when serviced or reset
// R9: master reset clears registers, sets outputs
// R10: user outputs follow bits 2 and 3
// R11: receiver runs from sixteen-times baud clock
// R12: read allowed when selected and strobe active
// R13: host ties unused read strobe inactive
// R14: msr bit 6 shows ring indicator
// R15: msr bit 2 flags ring rising edge
// R16: ring rising edge interrupts when enabled
// R17: clear to send bit 4, change bit 0
// R18: carrier detect bit 7, change bit 3
// R19: request to send follows mcr bit 1
// R20: msr read clears change flags, rearms
`timescale 1ns/100ps
`default_nettype none
`include "umc_defines.vh"
module umc_top #(
  parameter RX_DIV = `UMC_RX_DIV_DEFAULT
) (
  input wire clk,
  input wire nrst,
  input wire master_reset_in,
  // avalon-mm slave
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // direct host pins
  input wire chip_select_in,
  input wire read_strobe_high,
  input wire read_strobe_low_n,
  output reg transceiver_disable_out,
  // modem pins, all active low
  input wire clear_to_send_n,
  input wire set_ready_n,
  input wire ring_indicator_n,
  input wire carrier_detect_n,
  output reg terminal_ready_n,
  output reg request_to_send_n,
  output reg user_output_a_n,
  output reg user_output_b_n,
  // interrupt sources from the data paths
  input wire rx_error_in,
  input wire rx_data_avail_in,
  input wire rx_timeout_in,
  input wire fifo_mode_in,
  input wire thr_empty_in,
  output reg host_irq_out,
  output reg rx_tick_out
);
  wire [3:0] modem_s;
  wire [3:0] host_s;
  reg [7:0] mcr_r;
  reg [7:0] ier_r;
  reg [3:0] delta_r;
  reg [3:0] prev_r;
  reg thre_pend_r;
  reg thr_prev_r;
  reg [15:0] div_r;
  reg [7:0] iid_nxt;
  reg [31:0] rdata_nxt;
  wire [3:0] level;
  wire [3:0] change;
  wire rst_any;
  wire loop_mode;
  wire host_rd;
  wire msr_rd;
  wire iir_rd;
  wire ms_int;
  wire ack;
  // next values of the control and flag registers
  wire bus_wr;
  wire thre_arm;
  wire thre_done;
  wire [3:0] out_bits;
  reg [7:0] mcr_nxt;
  reg [7:0] ier_nxt;
  reg [3:0] delta_nxt;
  reg thre_pend_nxt;
  reg [3:0] mout_nxt;
  genvar gi;

  umc_sync #(.W(4)) u_modem_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n}),
    .sync_out(modem_s)
  );
  // host pins enter at their active-low sense so the flops reset to the idle level
  umc_sync #(.W(4)) u_host_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({~master_reset_in, ~chip_select_in, read_strobe_low_n, ~read_strobe_high}),
    .sync_out(host_s)
  );

  // master reset acts synchronously after the synchroniser, two edges late
  assign rst_any = ~host_s[3]; // [R9]
  assign loop_mode = mcr_r[`UMC_MCR_LOOP];
  // either strobe while selected opens a read; select shares the flops so both stay aligned
  assign host_rd = ~host_s[2] & (~host_s[0] | ~host_s[1]); // [R12] [R13]
  // status bits are true when the active-low pin is low
  assign level = ~modem_s; // {carrier, ring, set ready, clear to send}
  // per-input change detect; the ring input counts only its trailing edge, when the pin returns high
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chg
      if (gi == `UMC_MSR_RING_END) begin : g_trail
        assign change[gi] = ~level[gi] & prev_r[gi]; // [R15]
      end else begin : g_any
        assign change[gi] = level[gi] ^ prev_r[gi]; // [R3] [R17] [R18]
      end
    end
  endgenerate
  // a request is taken on its first edge, while waitrequest still stands high
  assign ack = (avs_read | avs_write) & avs_waitrequest;
  assign bus_wr = avs_write & ack;
  assign msr_rd = avs_read & ack & (avs_address == `UMC_ADDR_MSR);
  assign iir_rd = avs_read & ack & (avs_address == `UMC_ADDR_IIR);
  assign ms_int = ier_r[`UMC_IER_MS] & (|delta_r); // [R4] [R16]

  // one wait state, answer on the second edge of each request
  // the master may start a new request on the edge after the answer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (ack) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // next control values; master reset outranks a bus write in the same cycle
  // writes to status and identity are dropped, those registers are read only
  always @* begin
    mcr_nxt = mcr_r;
    ier_nxt = ier_r;
    if (rst_any) begin
      mcr_nxt = `UMC_MCR_RESET; // [R9]
      ier_nxt = `UMC_IER_RESET;
    end else if (bus_wr) begin
      case (avs_address)
        `UMC_ADDR_MCR: mcr_nxt = {3'h0, avs_writedata[4:0]};
        `UMC_ADDR_IER: ier_nxt = {4'h0, avs_writedata[3:0]};
        default: mcr_nxt = mcr_r;
      endcase
    end
  end

  // control registers written from the bus
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcr_r <= `UMC_MCR_RESET;
      ier_r <= `UMC_IER_RESET;
    end else begin
      mcr_r <= mcr_nxt;
      ier_r <= ier_nxt;
    end
  end

  // change flags: a new change in the read cycle survives the clear
  // software that reads too seldom sees several changes merged into one flag
  always @* begin
    if (rst_any) begin
      delta_nxt = 4'h0;
    end else begin
      delta_nxt = (msr_rd ? 4'h0 : delta_r) | change; // [R20] [R3] [R15] [R17] [R18]
    end
  end

  // the pin history keeps following in reset, so leaving it raises no false flag
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delta_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      delta_r <= delta_nxt;
      prev_r <= level;
    end
  end

  // holding-empty interrupt is armed on the rising edge, cleared by identity read
  assign thre_arm = thr_empty_in & ~thr_prev_r;
  assign thre_done = (iir_rd & (iid_nxt == `UMC_IID_THRE)) | ~thr_empty_in;
  // arming wins over a clearing read in the same cycle
  always @* begin
    thre_pend_nxt = thre_pend_r;
    if (rst_any) begin
      thre_pend_nxt = 1'b0;
    end else if (thre_arm) begin
      thre_pend_nxt = 1'b1;
    end else if (thre_done) begin
      thre_pend_nxt = 1'b0; // [R8]
    end
  end

  // history is held low in reset so an empty holding register rearms after it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thre_pend_r <= 1'b0;
      thr_prev_r <= 1'b0;
    end else begin
      thre_pend_r <= thre_pend_nxt;
      thr_prev_r <= thr_empty_in & ~rst_any;
    end
  end

  // prioritised interrupt identity
  always @* begin
    iid_nxt = `UMC_IID_NONE;
    if (ier_r[`UMC_IER_RLS] & rx_error_in) begin
      iid_nxt = `UMC_IID_RLS; // [R7]
    end else if (ier_r[`UMC_IER_RDA] & rx_data_avail_in) begin
      iid_nxt = `UMC_IID_RDA;
    end else if (ier_r[`UMC_IER_RDA] & fifo_mode_in & rx_timeout_in) begin
      iid_nxt = `UMC_IID_TMO; // timeout only counts in fifo mode
    end else if (ier_r[`UMC_IER_THRE] & thre_pend_r) begin
      iid_nxt = `UMC_IID_THRE;
    end else if (ms_int) begin
      iid_nxt = `UMC_IID_MS;
    end
  end

  // read data mux, unmapped bits read zero
  // the status read shows the flags as they stood before the clearing edge
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      `UMC_ADDR_MCR: rdata_nxt = {24'h0, mcr_r};
      `UMC_ADDR_MSR: rdata_nxt = {24'h0, level, delta_r}; // [R2] [R14] [R17] [R18]
      `UMC_ADDR_IER: rdata_nxt = {24'h0, ier_r};
      `UMC_ADDR_IIR: rdata_nxt = {24'h0, iid_nxt};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ack) begin
      avs_readdata <= rdata_nxt;
    end
  end

  // modem outputs: inactive high on reset, in loop mode or with the bit cleared
  assign out_bits = {mcr_r[`UMC_MCR_OUTB], mcr_r[`UMC_MCR_OUTA], mcr_r[`UMC_MCR_RTS], mcr_r[`UMC_MCR_DTR]};
  always @* begin
    mout_nxt = ~(out_bits & {4{~loop_mode & ~rst_any}}); // [R5] [R6] [R10] [R19]
  end

  // each pin has its own flop so no decode glitch reaches the modem
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      terminal_ready_n <= 1'b1;
      request_to_send_n <= 1'b1;
      user_output_a_n <= 1'b1;
      user_output_b_n <= 1'b1;
    end else begin
      terminal_ready_n <= mout_nxt[0]; // [R5] [R6]
      request_to_send_n <= mout_nxt[1]; // [R19]
      user_output_a_n <= mout_nxt[2]; // [R10]
      user_output_b_n <= mout_nxt[3]; // [R10]
    end
  end

  // interrupt pin and transceiver disable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_irq_out <= 1'b0;
      transceiver_disable_out <= 1'b1;
    end else begin
      host_irq_out <= ~rst_any & ~iid_nxt[0]; // [R7] [R8]
      transceiver_disable_out <= ~host_rd; // [R1]
    end
  end

  // receiver 16x enable from a divider, a stand-in for the dedicated clock pin
  // one clock avoids a second domain; the clk rate divided by RX_DIV sets the receiver rate
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 16'h0000;
      rx_tick_out <= 1'b0;
    end else if (div_r >= RX_DIV - 16'h0001) begin
      div_r <= 16'h0000;
      rx_tick_out <= 1'b1; // [R11]
    end else begin
      div_r <= div_r + 16'h0001;
      rx_tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: design/umc_defines.vh */
// constants for the modem control and status block
`ifndef UMC_DEFINES_VH
`define UMC_DEFINES_VH
// register word addresses (byte address = index * 4)
`define UMC_ADDR_MCR 2'h0
`define UMC_ADDR_MSR 2'h1
`define UMC_ADDR_IER 2'h2
`define UMC_ADDR_IIR 2'h3
// modem control fields
`define UMC_MCR_DTR 0
`define UMC_MCR_RTS 1
`define UMC_MCR_OUTA 2
`define UMC_MCR_OUTB 3
`define UMC_MCR_LOOP 4
`define UMC_MCR_RESET 8'h00
// modem status fields
`define UMC_MSR_CTS_CHG 0
`define UMC_MSR_DSR_CHG 1
`define UMC_MSR_RING_END 2
`define UMC_MSR_CAR_CHG 3
`define UMC_MSR_CTS 4
`define UMC_MSR_DSR 5
`define UMC_MSR_RING 6
`define UMC_MSR_CARRIER 7
// interrupt enable fields
`define UMC_IER_RDA 0
`define UMC_IER_THRE 1
`define UMC_IER_RLS 2
`define UMC_IER_MS 3
`define UMC_IER_RESET 8'h00
// interrupt identity codes, bit 0 high means nothing pending
`define UMC_IID_NONE 8'h01
`define UMC_IID_RLS 8'h06
`define UMC_IID_RDA 8'h04
`define UMC_IID_TMO 8'h0C
`define UMC_IID_THRE 8'h02
`define UMC_IID_MS 8'h00
// 16x receiver clock divisor default
`define UMC_RX_DIV_DEFAULT 16'h0036
`endif

/* File: design/umc_sync.v */
// two-flop synchroniser bank for the modem and host inputs
`timescale 1ns/100ps
`default_nettype none
module umc_sync #(
  parameter W = 4
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      // first flop feeds only the second one
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_r <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_r <= async_in[i];
          sync_out[i] <= meta_r;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: sim/umc_top_asserts.sv */
// port checker for the modem control block
`timescale 1ns/100ps
`default_nettype none
module umc_chk #(parameter RX_DIV = 4) (
  input wire clk,
  input wire nrst,
  input wire master_reset_in,
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire chip_select_in,
  input wire read_strobe_high,
  input wire transceiver_disable_out,
  input wire clear_to_send_n,
  input wire set_ready_n,
  input wire ring_indicator_n,
  input wire carrier_detect_n,
  input wire terminal_ready_n,
  input wire request_to_send_n,
  input wire user_output_a_n,
  input wire user_output_b_n,
  input wire host_irq_out,
  input wire rx_tick_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [3:0] pins = {carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n};
  wire rd_msr = avs_read && avs_waitrequest && avs_address == 2'h1;
  logic [7:0] gap_r;
  logic seen_r;
  // cycles since the last receiver tick; the first tick has no reference
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= rx_tick_out ? 8'h01 : gap_r + 8'h01;
      seen_r <= seen_r | rx_tick_out;
    end
  end
  rst_state_a: assert property ($rose(nrst) |-> avs_waitrequest && transceiver_disable_out && !host_irq_out)
    else $error("outputs off their reset state");
  mr_outs_a: assert property ($rose(master_reset_in) ##1 master_reset_in [*5] |-> terminal_ready_n &&
    request_to_send_n && user_output_a_n && user_output_b_n && !host_irq_out) else $error("master reset outputs");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  xcvr_idle_a: assert property ((!chip_select_in) [*4] |-> transceiver_disable_out)
    else $error("disable low while idle");
  xcvr_read_a: assert property ((chip_select_in && read_strobe_high) [*5] |-> !transceiver_disable_out)
    else $error("disable high during read");
  msr_live_a: assert property ($stable(pins) [*6] ##0 rd_msr |=> avs_readdata[7:4] == ~$past(pins))
    else $error("status bits wrong");
  msr_clear_a: assert property ($stable(pins) [*2] ##0 rd_msr ##1 $stable(pins) [*3] ##0 rd_msr |=>
    avs_readdata[3:0] == 4'h0)
    else $error("change flags not cleared");
  rx_rate_a: assert property (rx_tick_out && seen_r |-> gap_r == RX_DIV)
    else $error("receiver tick spacing");
endmodule
bind umc_top umc_chk #(.RX_DIV(RX_DIV)) chk_i (.clk(clk), .nrst(nrst), .master_reset_in(master_reset_in),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .chip_select_in(chip_select_in), .read_strobe_high(read_strobe_high),
  .transceiver_disable_out(transceiver_disable_out), .clear_to_send_n(clear_to_send_n),
  .set_ready_n(set_ready_n), .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n),
  .terminal_ready_n(terminal_ready_n), .request_to_send_n(request_to_send_n), .user_output_a_n(user_output_a_n),
  .user_output_b_n(user_output_b_n), .host_irq_out(host_irq_out), .rx_tick_out(rx_tick_out));
`default_nettype wire

/* File: sim/umc_modem.sv */
// data set model answering the terminal control lines
`timescale 1ns/100ps
`default_nettype none
module umc_modem #(parameter DLY = 3) (
  input wire clk,
  input wire rts_n,
  input wire dtr_n,
  input wire ring_req,
  input wire carrier_req,
  output wire logic cts_n,
  output wire logic dsr_n,
  output wire logic ring_n,
  output wire logic carrier_n
);
  logic [DLY-1:0] cts_q = '1;
  logic [DLY-1:0] dsr_q = '1;
  // handshake lines answer after DLY clocks, so a slow modem is one parameter away
  always @(posedge clk) begin
    cts_q <= {cts_q[DLY-2:0], rts_n};
    dsr_q <= {dsr_q[DLY-2:0], dtr_n};
  end
  assign cts_n = cts_q[DLY-1];
  assign dsr_n = dsr_q[DLY-1];
  assign ring_n = !ring_req;
  assign carrier_n = !carrier_req;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench for the modem control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, mreset = 1'b0, rd = 1'b0, wr = 1'b0, cs = 1'b0, rsh = 1'b0, rsl_n = 1'b1;
  logic ring = 1'b0, car = 1'b0, fifo = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [3:0] src = 4'h0;
  logic [31:0] wdata = 32'h0, q;
  logic [7:0] codes [4] = '{8'h06, 8'h04, 8'h0C, 8'h02};
  wire [31:0] rdata;
  wire wq, dis, cts_n, dsr_n, ring_n, carrier_n, dtr_n, rts_n, oa_n, ob_n, irq, tick;
  int fail_count = 0, cmp_count = 0, ticks = 0, t0;
  always #5 clk = ~clk;
  umc_top #(.RX_DIV(4)) uut (.clk(clk), .nrst(nrst), .master_reset_in(mreset), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wq), .chip_select_in(cs),
    .read_strobe_high(rsh), .read_strobe_low_n(rsl_n), .transceiver_disable_out(dis), .clear_to_send_n(cts_n),
    .set_ready_n(dsr_n), .ring_indicator_n(ring_n), .carrier_detect_n(carrier_n), .terminal_ready_n(dtr_n),
    .request_to_send_n(rts_n), .user_output_a_n(oa_n), .user_output_b_n(ob_n), .rx_error_in(src[0]),
    .rx_data_avail_in(src[1]), .rx_timeout_in(src[2]), .fifo_mode_in(fifo), .thr_empty_in(src[3]),
    .host_irq_out(irq), .rx_tick_out(tick));
  umc_modem #(.DLY(3)) far (.clk(clk), .rts_n(rts_n), .dtr_n(dtr_n), .ring_req(ring), .carrier_req(car),
    .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n), .carrier_n(carrier_n));
  // receiver ticks seen so far; non-blocking so readers at the edge see a settled count
  always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus cycle; the extra edge keeps back-to-back calls from driving a strobe twice per step
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string name);
    bus(1'b0, a, 32'h0);
    chk(name, q, {24'h0, e});
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, about five times the expected run
  initial begin
    #10000;
    fail_count++;
    close_out();
  end
  initial begin
    cyc(6);
    nrst <= 1'b1;
    cyc(1);
    chk("pins", {dis, irq, dtr_n, rts_n, oa_n, ob_n}, 6'h2F);
    rdc(2'h0, 8'h00, "mcr");
    bus(1'b0, 2'h1, 32'h0);
    bus(1'b1, 2'h0, 32'h0F);
    cyc(3);
    chk("outs on", {dtr_n, rts_n, oa_n, ob_n}, 4'h0);
    cyc(10);
    rdc(2'h1, 8'h33, "msr hs");
    rdc(2'h1, 8'h30, "msr again");
    bus(1'b1, 2'h2, 32'h08);
    bus(1'b1, 2'h0, 32'h0E);
    cyc(12);
    chk("dtr off", dtr_n, 1'b1);
    chk("irq dsr", irq, 1'b1);
    rdc(2'h1, 8'h12, "msr dsr");
    chk("irq served", irq, 1'b0);
    car <= 1'b1;
    cyc(8);
    chk("irq car", irq, 1'b1);
    rdc(2'h1, 8'h98, "msr car");
    ring <= 1'b1;
    cyc(8);
    chk("irq ring on", irq, 1'b0);
    rdc(2'h1, 8'hD0, "msr ring");
    ring <= 1'b0;
    cyc(8);
    chk("irq ring end", irq, 1'b1);
    rdc(2'h1, 8'h94, "msr ring end");
    bus(1'b1, 2'h0, 32'h1F);
    cyc(3);
    chk("outs loop", {dtr_n, rts_n, oa_n, ob_n}, 4'hF);
    bus(1'b1, 2'h0, 32'h0F);
    bus(1'b1, 2'h2, 32'h07);
    fifo <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      src <= 4'h1 << i;
      cyc(3);
      chk("irq src", irq, 1'b1);
      rdc(2'h3, codes[i], "iir");
      src <= 4'h0;
      cyc(3);
      chk("irq off", irq, 1'b0);
    end
    src <= 4'h3;
    cyc(3);
    rdc(2'h3, 8'h06, "iir prio");
    src <= 4'h4;
    fifo <= 1'b0;
    cyc(3);
    chk("tmo no fifo", irq, 1'b0);
    src <= 4'h0;
    cs <= 1'b1;
    rsh <= 1'b1;
    cyc(5);
    chk("dis rd", dis, 1'b0);
    rsh <= 1'b0;
    rsl_n <= 1'b0;
    cyc(5);
    chk("dis rd low", dis, 1'b0);
    cs <= 1'b0;
    cyc(5);
    chk("dis idle", dis, 1'b1);
    rsl_n <= 1'b1;
    mreset <= 1'b1;
    cyc(8);
    mreset <= 1'b0;
    chk("outs mr", {dtr_n, rts_n, oa_n, ob_n}, 4'hF);
    rdc(2'h0, 8'h00, "mcr mr");
    t0 = ticks;
    cyc(40);
    chk("ticks", ticks - t0, 32'h0000_000A);
    close_out();
  end
endmodule
`default_nettype wire
